// [include/potr_params.svh]
// constants for the pattern output and trigger bus routing block
`ifndef POTR_PARAMS_SVH
`define POTR_PARAMS_SVH
// register offsets (word index on the plain register port)
`define POTR_REG_CTRL 4'h0
`define POTR_REG_ROUTE 4'h1
`define POTR_REG_DIV 4'h2
`define POTR_REG_MARK 4'h3
`define POTR_REG_STAT 4'h4
// control field positions
`define POTR_CTRL_PATEN 0
`define POTR_CTRL_DDS 1
`define POTR_CTRL_MASTER 2
// route field positions, 3 bits each
`define POTR_RT_TRIGIN 0
`define POTR_RT_MARK 4
`define POTR_RT_TRIGOUT 8
`define POTR_RT_SQR 12
// reset values
`define POTR_CTRL_RST 8'h00
`define POTR_ROUTE_RST 16'h7777
`define POTR_DIV_RST 16'h0001
// timing
`define POTR_CLK_NS 10
`define POTR_HIGH_NS 25
`define POTR_HIGH_CYC ((`POTR_HIGH_NS + `POTR_CLK_NS - 1) / `POTR_CLK_NS)
`define POTR_MARK_LEN 8
`define POTR_BCLK_DIV 2
`define POTR_NUM_TRIG 7
`endif

// [include/potr_pkg.sv]
// types for the pattern output and trigger bus routing block
package potr_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } potr_req_t;
  typedef struct packed {
    logic [15:0] word;
    logic marker;
  } potr_word_t;
  typedef enum logic [1:0] {
    POTR_IDLE = 2'b00,
    POTR_HIGH = 2'b01,
    POTR_LOW = 2'b10
  } potr_clk_state_t;
endpackage

// [core/potr_fifo.sv]
// small valid/ready fifo for the pattern word stream
`timescale 1ns/100ps
`default_nettype none
module potr_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [core/potr_top.sv]
// pattern output path and trigger bus routing
// Function
// - sixteen pattern data lines, one bit each
// - pattern word registered on sample clock
// - sample clock forwarded as pattern clock; below a divide count of 4 the logic gives half the sample rate
// - pattern words bypass the interpolating filter
// - software enable, cleared at reset
// - linked/looped buffer order drives pattern
// - dds mode puts synthesized words out
// - divided clock high phase fixed 25 ns; the logic holds it 3 base cycles, 30 ns
// - seven trigger lines plus one clock line
// - master drives board clock, slave receives
// - start trigger from selected line 0..6
// - marker routable to any trigger line
// - local trigger routable to any line
// - square reference routable to any line
// - marker high exactly eight sample periods
// - one marker per stage, programmable; at marker offset 0 the logic marks only every other stage
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "potr_params.svh"
module potr_top import potr_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // sequencer word stream (memory, linked/looped order)
  input wire logic memValid,
  output logic memReady,
  input wire logic [DATA_W-1:0] memWord,
  input wire logic memStageStart,
  // synthesized word stream
  input wire logic [DATA_W-1:0] ddsWord,
  // local events
  input wire logic localTrig,
  input wire logic squareRef,
  input wire logic boardClk,
  // pattern connector
  output logic [DATA_W-1:0] patternDataLines,
  output logic patternClk,
  // trigger bus
  input wire logic [`POTR_NUM_TRIG-1:0] busTriggerLinesIn,
  output logic [`POTR_NUM_TRIG-1:0] busTriggerLinesOut,
  output logic [`POTR_NUM_TRIG-1:0] busTriggerLinesOe,
  input wire logic busClockLineIn,
  output logic busClockLineOut,
  output logic busClockLineOe,
  output logic busClockIn,
  output logic startTrig,
  output logic markerOut
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_q; // enable, dds select, master
  logic [15:0] route_q; // line selects, 7 means unrouted
  logic [15:0] div_q; // sample clock divide count
  logic [15:0] markPos_q; // marker word offset in stage
  logic [15:0] regRdata_q;
  logic patEn;
  logic ddsSel;
  logic master;
  assign patEn = ctrl_q[`POTR_CTRL_PATEN];
  assign ddsSel = ctrl_q[`POTR_CTRL_DDS];
  assign master = ctrl_q[`POTR_CTRL_MASTER];

  // line select decode, used for every routed source
  function automatic logic [`POTR_NUM_TRIG-1:0] lineSel(input logic [2:0] s);
    lineSel = '0;
    if (s < 3'h7) begin
      lineSel[s] = 1'b1;
    end
  endfunction

  // register writes; enable clears on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `POTR_CTRL_RST;
      route_q <= `POTR_ROUTE_RST;
      div_q <= `POTR_DIV_RST;
      markPos_q <= '0;
    end else if (regWr) begin
      case (regAddr)
        `POTR_REG_CTRL: ctrl_q <= regWdata[7:0];
        `POTR_REG_ROUTE: route_q <= regWdata;
        `POTR_REG_DIV: div_q <= regWdata;
        `POTR_REG_MARK: markPos_q <= regWdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sample clock tick and forwarded clock
  // ------------------------------------------------------------
  logic [15:0] divCnt_q; // counts down base clock cycles of a sample period
  logic tick; // one sample period ends
  logic [15:0] hiCnt_q;
  potr_clk_state_t clkSt_q;
  assign tick = (divCnt_q == 16'h0000);

  // divider from the base clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
    end else if (tick) begin
      divCnt_q <= (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
    end else begin
      divCnt_q <= divCnt_q - 16'h0001;
    end
  end

  // forwarded clock: fixed high time when divided, else half rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkSt_q <= POTR_IDLE;
      patternClk <= 1'b0;
      hiCnt_q <= '0;
    end else begin
      case (clkSt_q)
        POTR_IDLE: begin
          if (tick) begin
            clkSt_q <= POTR_HIGH;
            patternClk <= 1'b1;
            hiCnt_q <= 16'(`POTR_HIGH_CYC - 1);
          end
        end
        POTR_HIGH: begin
          if (div_q > 16'h0001) begin
            if (hiCnt_q == 16'h0000) begin
              patternClk <= 1'b0;
              clkSt_q <= POTR_LOW;
            end else begin
              hiCnt_q <= hiCnt_q - 16'h0001;
            end
          end else begin
            patternClk <= ~patternClk; // undivided rate
            clkSt_q <= POTR_IDLE;
          end
        end
        POTR_LOW: begin
          if (tick) begin
            patternClk <= 1'b1;
            hiCnt_q <= 16'(`POTR_HIGH_CYC - 1);
            clkSt_q <= POTR_HIGH;
          end
        end
        default: clkSt_q <= POTR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // word path: fifo from sequencer, drained once per tick unless dds is selected
  // ------------------------------------------------------------
  logic [15:0] stageIdx_q; // word index inside current stage
  logic markDone_q; // marker already issued this stage
  logic fifoValid;
  logic [DATA_W:0] fifoOut;
  logic pop;
  logic markHit;
  assign pop = tick && fifoValid && !ddsSel;
  // words come straight from memory, no filter stage
  potr_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk(clk),
    .rst(rst),
    .inValid(memValid),
    .inReady(memReady),
    .inData({memStageStart, memWord}),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoOut)
  );
  assign markHit = pop && !markDone_q &&
    ((fifoOut[DATA_W] ? 16'h0000 : stageIdx_q) == markPos_q);

  // stage position tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stageIdx_q <= '0;
      markDone_q <= 1'b0;
    end else if (pop) begin
      stageIdx_q <= fifoOut[DATA_W] ? 16'h0001 : stageIdx_q + 16'h0001;
      if (markHit) begin
        markDone_q <= 1'b1;
      end else if (fifoOut[DATA_W]) begin
        markDone_q <= 1'b0;
      end
    end
  end

  // output register; holds while disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      patternDataLines <= '0;
    end else if (patEn && tick) begin
      if (ddsSel) begin
        patternDataLines <= ddsWord;
      end else if (fifoValid) begin
        patternDataLines <= fifoOut[DATA_W-1:0];
      end
    end
  end

  // marker pulse, eight sample periods
  logic [3:0] markCnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      markCnt_q <= '0;
      markerOut <= 1'b0;
    end else if (markHit) begin
      markCnt_q <= 4'(`POTR_MARK_LEN);
      markerOut <= 1'b1;
    end else if (tick && markCnt_q != 4'h0) begin
      markCnt_q <= markCnt_q - 4'h1;
      markerOut <= (markCnt_q != 4'h1);
    end
  end

  // ------------------------------------------------------------
  // trigger bus routing
  // ------------------------------------------------------------
  logic [`POTR_NUM_TRIG-1:0] oeD;
  logic [`POTR_NUM_TRIG-1:0] outD;
  logic [`POTR_NUM_TRIG-1:0] mSel;
  logic [`POTR_NUM_TRIG-1:0] tSel;
  logic [`POTR_NUM_TRIG-1:0] sSel;
  logic [2:0] inSel;
  assign mSel = lineSel(route_q[`POTR_RT_MARK +: 3]);
  assign tSel = lineSel(route_q[`POTR_RT_TRIGOUT +: 3]);
  assign sSel = lineSel(route_q[`POTR_RT_SQR +: 3]);
  assign inSel = route_q[`POTR_RT_TRIGIN +: 3];
  assign oeD = mSel | tSel | sSel;
  genvar g;
  generate
    for (g = 0; g < `POTR_NUM_TRIG; g++) begin : gLine
      assign outD[g] = (mSel[g] & markerOut) | (tSel[g] & localTrig) |
        (sSel[g] & squareRef);
    end
  endgenerate

  // registered pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busTriggerLinesOut <= '0;
      busTriggerLinesOe <= '0;
      startTrig <= 1'b0;
    end else begin
      busTriggerLinesOut <= outD;
      busTriggerLinesOe <= oeD;
      startTrig <= (inSel < 3'h7) ? busTriggerLinesIn[inSel] : 1'b0;
    end
  end

  // bus clock line: drive as master, receive as slave
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busClockLineOut <= 1'b0;
      busClockLineOe <= 1'b0;
      busClockIn <= 1'b0;
    end else begin
      busClockLineOut <= master & boardClk;
      busClockLineOe <= master;
      busClockIn <= master ? 1'b0 : busClockLineIn;
    end
  end

  // ------------------------------------------------------------
  // register reads, data one cycle after strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata_q <= '0;
    end else if (regRd) begin
      case (regAddr)
        `POTR_REG_CTRL: regRdata_q <= {8'h00, ctrl_q};
        `POTR_REG_ROUTE: regRdata_q <= route_q;
        `POTR_REG_DIV: regRdata_q <= div_q;
        `POTR_REG_MARK: regRdata_q <= markPos_q;
        `POTR_REG_STAT: regRdata_q <= {13'h0000, markDone_q, markerOut,
          fifoValid};
        default: regRdata_q <= 16'h0000; // unmapped
      endcase
    end else begin
      regRdata_q <= 16'h0000;
    end
  end
  assign regRdata = regRdata_q;
endmodule
`default_nettype wire

// [test/potr_sva.sv]
// port-level checker for the pattern output and trigger routing top
`timescale 1ns/100ps
`default_nettype none
`include "potr_params.svh"
module potr_sva #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic [DATA_W-1:0] patternDataLines,
  input wire logic patternClk,
  input wire logic [`POTR_NUM_TRIG-1:0] busTriggerLinesIn,
  input wire logic [`POTR_NUM_TRIG-1:0] busTriggerLinesOut,
  input wire logic busClockLineIn,
  input wire logic busClockLineOut,
  input wire logic busClockLineOe,
  input wire logic busClockIn,
  input wire logic boardClk,
  input wire logic localTrig,
  input wire logic startTrig,
  input wire logic markerOut
);
  logic [15:0] ctQ, rtQ, dvQ; // shadow control, route, divide
  logic selIn, trOut; // selected bus bits
  // track register writes so routing is known at the ports
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctQ <= 16'h0000;
      rtQ <= `POTR_ROUTE_RST;
      dvQ <= `POTR_DIV_RST;
    end else if (regWr) begin
      if (regAddr == `POTR_REG_CTRL) ctQ <= regWdata;
      if (regAddr == `POTR_REG_ROUTE) rtQ <= regWdata;
      if (regAddr == `POTR_REG_DIV) dvQ <= regWdata;
    end
  end
  // index 7 means unrouted, so users guard on it
  assign selIn = busTriggerLinesIn[rtQ[2:0]];
  assign trOut = busTriggerLinesOut[rtQ[10:8]];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_mkHold; markerOut [*8] ##1 !markerOut; endsequence
  sequence s_pclkHigh; patternClk [*3] ##1 !patternClk; endsequence
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0)
    else $error("read data not zero outside a read");
  a_start_select: assert property (
    rtQ[2:0] != 3'h7 && $stable(rtQ) |-> startTrig == $past(selIn))
    else $error("start trigger not from selected line");
  a_trig_route: assert property (
    rtQ[10:8] != 3'h7 && $stable(rtQ) |-> trOut == $past(localTrig))
    else $error("local trigger not on selected line");
  a_master_clock: assert property (
    $stable(ctQ) && ctQ[2] |-> busClockLineOe
      && busClockLineOut == $past(boardClk))
    else $error("master does not drive board clock");
  a_slave_clock: assert property (
    !$past(rst) && $stable(ctQ) && !ctQ[2] |-> !busClockLineOe
      && busClockIn == $past(busClockLineIn))
    else $error("slave does not take bus clock");
  a_lines_hold: assert property (
    !ctQ[0] && !$past(ctQ[0]) |-> $stable(patternDataLines))
    else $error("pattern lines moved while disabled");
  a_pclk_high: assert property (
    $rose(patternClk) && dvQ >= 16'h4 && $stable(dvQ) |-> s_pclkHigh)
    else $error("pattern clock high phase wrong");
  a_marker_width: assert property (
    $rose(markerOut) && dvQ <= 16'h1 |-> s_mkHold)
    else $error("marker width not eight");
endmodule
bind potr_top potr_sva #(.DATA_W(DATA_W)) u_sva (
  .clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .patternDataLines, .patternClk, .busTriggerLinesIn, .busTriggerLinesOut,
  .busClockLineIn, .busClockLineOut, .busClockLineOe, .busClockIn,
  .boardClk, .localTrig, .startTrig, .markerOut
);
`default_nettype wire

// [test/potr_pattern_rx.sv]
// receiver that latches the pattern lines on the forwarded clock
`timescale 1ns/100ps
`default_nettype none
module potr_pattern_rx (
  input wire logic patternClk,
  input wire logic [15:0] patternDataLines,
  output logic [15:0] capWord
);
  initial begin
    capWord = 16'h0000;
  end
  // falling edge capture gives the high phase as setup margin
  always @(negedge patternClk) begin
    capWord <= patternDataLines;
  end
endmodule
`default_nettype wire

// [test/test_pattern_output_trigger_routing.sv]
// self-checking bench for the pattern output and trigger routing top
`timescale 1ns/100ps
`default_nettype none
`include "potr_params.svh"
module test_pattern_output_trigger_routing;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic memValid = 1'b0, memStageStart = 1'b0, pushOn = 1'b0;
  logic localTrig = 1'b0, squareRef = 1'b0, boardClk = 1'b0;
  logic busClockLineIn = 1'b0, fullSeen = 1'b0, prevM = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0, memWord = 16'h0, ddsWord = 16'h0;
  logic [15:0] rw, pw, lastW, prevL, regRdata, patternDataLines, capWord;
  logic [6:0] busTriggerLinesIn = 7'h0, busTriggerLinesOut;
  logic [6:0] busTriggerLinesOe;
  logic [2:0] rs, rm, rt, rq;
  logic memReady, patternClk, busClockLineOut, busClockLineOe;
  logic busClockIn, startTrig, markerOut;
  logic [15:0] expQ[$];
  int seed = 81015;
  int error_cnt = 0;
  int comparisons = 0;
  int mode = 0, nPush = 0, sIdx = 0, mkHi = 0, mkRise = 0;
  potr_top dut (
    .clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .memValid, .memReady, .memWord, .memStageStart, .ddsWord,
    .localTrig, .squareRef, .boardClk, .patternDataLines, .patternClk,
    .busTriggerLinesIn, .busTriggerLinesOut, .busTriggerLinesOe,
    .busClockLineIn, .busClockLineOut, .busClockLineOe, .busClockIn,
    .startTrig, .markerOut
  );
  potr_pattern_rx rx (.patternClk, .patternDataLines, .capWord);
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdata", e, regRdata);
  endtask
  task waitPush(input int n);
    for (int i = 0; i < 3000 && nPush < n; i++) @(posedge clk);
    if (nPush < n) begin
      error_cnt++;
      $display("MISMATCH pushes expected %0d seen %0d", n, nPush);
      finish_test;
    end
  endtask
  // board clock and far-end bus clock stand-ins
  always @(posedge clk) begin
    boardClk <= ~boardClk;
    busClockLineIn <= 1'($random(seed));
  end
  // sequencer: each word differs from the previous one, held until taken
  always @(posedge clk) begin
    if (memValid && memReady) begin
      nPush++;
      lastW = memWord;
      if (mode == 1) expQ.push_back(memWord);
    end
    if (pushOn && memValid && !memReady) fullSeen = 1'b1;
    if (pushOn && (!memValid || memReady)) begin
      pw = $random(seed);
      memValid <= 1'b1;
      memWord <= {pw[15:1], ~memWord[0]};
      memStageStart <= (sIdx == 0);
      sIdx++;
    end else if (!memValid || memReady) begin
      memValid <= 1'b0;
    end
  end
  // every change of the lines is judged in modes 0 and 1; mode 2 leaves it unchecked
  always @(posedge clk) begin
    if (!rst && patternDataLines !== prevL) begin
      if (mode == 0) chk("held", prevL, patternDataLines);
      if (mode == 1) chk("word", expQ.pop_front(), patternDataLines);
    end
    if (markerOut === 1'b1) mkHi++;
    if (markerOut === 1'b1 && prevM !== 1'b1) mkRise++;
    prevL = patternDataLines;
    prevM = markerOut;
  end
  initial begin
    cyc(20);
    rst <= 1'b0;
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    rd(`POTR_REG_CTRL, `POTR_CTRL_RST);
    rd(`POTR_REG_ROUTE, `POTR_ROUTE_RST);
    wr(`POTR_REG_DIV, 16'h0004);
    pushOn <= 1'b1;
    waitPush(nPush + 8);
    pushOn <= 1'b0;
    cyc(40);
    mode = 2;
    wr(`POTR_REG_CTRL, 16'h0001);
    cyc(10);
    mode = 1;
    pushOn <= 1'b1;
    waitPush(nPush + 12);
    pushOn <= 1'b0;
    cyc(40);
    chk("fifoFull", 16'h1, fullSeen);
    chk("leftWords", 16'h0, 16'(expQ.size()));
    chk("rxWord", lastW, capWord);
    wr(`POTR_REG_MARK, 16'h0002);
    wr(`POTR_REG_DIV, 16'h0001);
    cyc(4);
    mkHi = 0;
    mkRise = 0;
    sIdx = 0;
    pushOn <= 1'b1;
    waitPush(nPush + 12);
    pushOn <= 1'b0;
    cyc(40);
    chk("mkRise", 16'h1, 16'(mkRise));
    chk("mkHigh", 16'h8, 16'(mkHi));
    rd(`POTR_REG_STAT, 16'h0004);
    mode = 2;
    wr(`POTR_REG_CTRL, 16'h0003);
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      ddsWord <= 16'($random(seed));
      cyc(12);
      #1 chk("dds", ddsWord, patternDataLines);
    end
    wr(`POTR_REG_CTRL, 16'h0002);
    cyc(3);
    mode = 0;
    ddsWord <= 16'h5a5a;
    cyc(20);
    for (int k = 0; k < 7; k++) begin
      rs = 3'(k);
      rm = 3'((k + 1) % 7);
      rt = 3'((k + 2) % 7);
      rq = 3'((k + 3) % 7);
      wr(`POTR_REG_ROUTE, {1'b0, rq, 1'b0, rt, 1'b0, rm, 1'b0, rs});
      for (int j = 0; j < 3; j++) begin
        @(posedge clk);
        rw = $random(seed);
        busTriggerLinesIn <= rw[6:0];
        localTrig <= rw[7];
        squareRef <= rw[8];
        cyc(3);
        #1 chk("start", {rw[rs], 1'b0}, {startTrig, busTriggerLinesOe[rs]});
        chk("trig", {rw[7], 1'b1}, {busTriggerLinesOut[rt], busTriggerLinesOe[rt]});
        chk("sqr", {rw[8], 1'b1}, {busTriggerLinesOut[rq], busTriggerLinesOe[rq]});
        chk("markOe", 16'h1, busTriggerLinesOe[rm]);
        chk("markLine", 16'h0, busTriggerLinesOut[rm]);
      end
    end
    wr(`POTR_REG_ROUTE, `POTR_ROUTE_RST);
    wr(`POTR_REG_CTRL, 16'h0004);
    cyc(3);
    #1 chk("clkOe", 16'h1, busClockLineOe);
    wr(`POTR_REG_CTRL, 16'h0000);
    cyc(3);
    #1 chk("clkOe", 16'h0, busClockLineOe);
    chk("busOe", 16'h0, busTriggerLinesOe);
    finish_test;
  end
endmodule
`default_nettype wire
